// *** rtl/mlf_top.sv ***
// Motor lock fault response: settings, lock detection gating, bridge action and recovery
// How it works
// - Codes 0-3 latch fault, set bridge state
// - Codes 4-7 hold bridge, recover after wait
// - Code 8 reports lock, bridge untouched
// - Codes 9 to F disable lock detection
// - Brakes switch all high or low switches
// - Wait field picks 100 to 10000 ms
// - Second settings register at 94h, resets zero
// - Bit 30 enables abnormal speed lock
// - Bit 29 enables sync loss lock
// - Bit 28 enables no-motor lock
// - Trip point 250 Hz steps up to 4000
// - Recovery attempts limited by three-bit field
module mlf_top #(
	parameter int unsigned TICK_CYCLES = mlf_pkg::TICK_CYCLES
) (
	input  wire logic                         mclk,
	input  wire logic                         resetn,
	input  wire logic [mlf_pkg::ADDR_W-1:0]   addr,
	input  wire logic [mlf_pkg::DATA_W-1:0]   wdata,
	input  wire logic                         wr_en,
	input  wire logic                         rd_en,
	output logic      [mlf_pkg::DATA_W-1:0]   rdata,
	input  wire logic [mlf_pkg::SPEED_W-1:0]  elec_speed_hz,
	input  wire logic                         sync_loss_lock,
	input  wire logic                         no_motor_lock,
	output logic                              fault_out_n,
	output logic                              bridge_hold,
	output logic                              bridge_tristate,
	output logic                              bridge_recirc,
	output logic      [2:0]                   hs_on,
	output logic      [2:0]                   ls_on,
	output logic                              irq
);
	logic [mlf_pkg::DATA_W-1:0]   cfg1_r;
	logic [mlf_pkg::DATA_W-1:0]   cfg2_r;
	logic [mlf_pkg::ST_W-1:0]     status_r;
	logic [mlf_pkg::ST_W-1:0]     status_nxt;
	logic [mlf_pkg::ST_W-1:0]     mask_r;
	logic [mlf_pkg::ST_W-1:0]     set_w;
	logic [mlf_pkg::CNT_W-1:0]    attempts_r;
	logic [mlf_pkg::CNT_W-1:0]    attempts_nxt;
	mlf_pkg::mlf_state_t          state_r;
	mlf_pkg::mlf_state_t          state_nxt;
	mlf_pkg::mlf_action_t         action_r;
	mlf_pkg::mlf_action_t         action_nxt;
	logic                         start_w;
	logic [mlf_pkg::DATA_W-1:0]   rdata_r;
	logic                         fault_n_r;
	logic                         hold_r;
	logic                         tri_r;
	logic                         recirc_r;
	logic [2:0]                   hs_r;
	logic [2:0]                   ls_r;
	logic                         irq_r;

	wire  [mlf_pkg::MODE_W-1:0]   mode_w;
	wire  [mlf_pkg::WAIT_W-1:0]   wait_code_w;
	wire  [mlf_pkg::CNT_W-1:0]    limit_w;
	wire  [mlf_pkg::SPEED_W-1:0]  trip_w;
	wire                          abn_lock_w;
	wire                          sync_lock_w;
	wire                          nomtr_lock_w;
	wire                          detect_on_w;
	wire                          lock_ev_w;
	wire                          is_latch_w;
	wire                          limit_hit_w;
	wire                          wr_cfg1_w;
	wire                          wr_cfg2_w;
	wire                          wr_stat_w;
	wire                          wr_mask_w;
	wire                          clear_w;
	wire                          hold_nxt_w;
	wire  [mlf_pkg::ST_W-1:0]     stat_clr_w;
	wire  [mlf_pkg::DATA_W-1:0]   state_word_w;
	wire  [mlf_pkg::DATA_W-1:0]   rd_mux_w;

	mlf_if tim ();

	mlf_timer #(
		.TICK_CYCLES (TICK_CYCLES)
	) u_timer (
		.mclk   (mclk),
		.resetn (resetn),
		.tif    (tim.tmr)
	);

	// Field extraction from the settings registers
	assign mode_w      = cfg1_r[mlf_pkg::MODE_LSB +: mlf_pkg::MODE_W];
	assign wait_code_w = cfg1_r[mlf_pkg::WAIT_LSB +: mlf_pkg::WAIT_W];
	assign limit_w     = mlf_pkg::retry_limit(cfg2_r[mlf_pkg::LIMIT_LSB +: mlf_pkg::LIMIT_W]);
	assign trip_w      = mlf_pkg::trip_hz(cfg2_r[mlf_pkg::THR_LSB +: mlf_pkg::THR_W]);

	// Per-type lock enables; detector pulses share this clock so need no synchroniser
	assign abn_lock_w   = cfg2_r[mlf_pkg::ABN_EN_BIT] && (elec_speed_hz > trip_w);
	assign sync_lock_w  = cfg2_r[mlf_pkg::SYNC_EN_BIT] && sync_loss_lock;
	assign nomtr_lock_w = cfg2_r[mlf_pkg::NOMTR_EN_BIT] && no_motor_lock;
	assign detect_on_w  = mode_w < mlf_pkg::MODE_OFF_MIN;
	assign lock_ev_w    = detect_on_w && (abn_lock_w || sync_lock_w || nomtr_lock_w);
	assign is_latch_w   = mode_w < mlf_pkg::MODE_AUTO_MIN;
	assign limit_hit_w  = (limit_w != '0) && (attempts_r >= limit_w);

	// Register decode
	assign wr_cfg1_w  = wr_en && (addr == mlf_pkg::OFF_CFG1);
	assign wr_cfg2_w  = wr_en && (addr == mlf_pkg::OFF_CFG2);
	assign wr_stat_w  = wr_en && (addr == mlf_pkg::OFF_STAT);
	assign wr_mask_w  = wr_en && (addr == mlf_pkg::OFF_MASK);
	assign clear_w    = wr_en && (addr == mlf_pkg::OFF_CTRL) && wdata[mlf_pkg::CTRL_CLEAR];
	assign stat_clr_w = wr_stat_w ? wdata[mlf_pkg::ST_W-1:0] : '0;

	// Read selection, unmapped offsets read as zero
	assign state_word_w = {22'h000000, attempts_r, action_r, state_r == mlf_pkg::MLF_WAIT,
		state_r == mlf_pkg::MLF_LATCHED, !fault_n_r};
	assign rd_mux_w = (addr == mlf_pkg::OFF_CFG1)  ? cfg1_r :
	                  (addr == mlf_pkg::OFF_CFG2)  ? cfg2_r :
	                  (addr == mlf_pkg::OFF_STAT)  ? {28'h0000000, status_r} :
	                  (addr == mlf_pkg::OFF_MASK)  ? {28'h0000000, mask_r} :
	                  (addr == mlf_pkg::OFF_STATE) ? state_word_w : 32'h00000000;

	// Timer request
	assign tim.start   = start_w;
	assign tim.wait_ms = mlf_pkg::wait_ms(wait_code_w);

	// Response state machine
	always_comb begin
		state_nxt    = state_r;
		action_nxt   = action_r;
		attempts_nxt = clear_w ? '0 : attempts_r;
		start_w      = 1'b0;
		set_w        = '0;
		set_w[mlf_pkg::ST_LOCK] = lock_ev_w;
		case (state_r)
			mlf_pkg::MLF_IDLE: begin
				if (lock_ev_w && (mode_w != mlf_pkg::MODE_REPORT)) begin
					action_nxt = mlf_pkg::mlf_action_t'(mode_w[1:0]);
					if (is_latch_w) begin
						state_nxt = mlf_pkg::MLF_LATCHED;
						set_w[mlf_pkg::ST_LATCH] = 1'b1;
					end else if (limit_hit_w) begin
						state_nxt = mlf_pkg::MLF_LATCHED;
						set_w[mlf_pkg::ST_LATCH] = 1'b1;
						set_w[mlf_pkg::ST_LIMIT] = 1'b1;
					end else begin
						state_nxt    = mlf_pkg::MLF_WAIT;
						start_w      = 1'b1;
						attempts_nxt = attempts_r + mlf_pkg::CNT_W'(1);
					end
				end
			end
			mlf_pkg::MLF_WAIT: begin
				if (tim.done) begin
					state_nxt = mlf_pkg::MLF_IDLE;
					set_w[mlf_pkg::ST_RECOV] = 1'b1;
				end
			end
			mlf_pkg::MLF_LATCHED: begin
				if (clear_w) begin
					state_nxt = mlf_pkg::MLF_IDLE;
				end
			end
			default: begin
				state_nxt = mlf_pkg::MLF_IDLE;
			end
		endcase
	end

	// Sticky status: a new event wins over a write-one clear in the same cycle
	assign status_nxt = (status_r & ~stat_clr_w) | set_w;
	assign hold_nxt_w = state_nxt != mlf_pkg::MLF_IDLE;

	// Settings and status registers
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			cfg1_r   <= mlf_pkg::CFG1_RST;
			cfg2_r   <= mlf_pkg::CFG2_RST;
			status_r <= '0;
			mask_r   <= '0;
		end else begin
			cfg1_r   <= wr_cfg1_w ? wdata : cfg1_r;
			cfg2_r   <= wr_cfg2_w ? wdata : cfg2_r;
			status_r <= status_nxt;
			mask_r   <= wr_mask_w ? wdata[mlf_pkg::ST_W-1:0] : mask_r;
		end
	end

	// Controller state
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			state_r    <= mlf_pkg::MLF_IDLE;
			action_r   <= mlf_pkg::MLF_TRISTATE;
			attempts_r <= '0;
		end else begin
			state_r    <= state_nxt;
			action_r   <= action_nxt;
			attempts_r <= attempts_nxt;
		end
	end

	// Outputs registered from next state so they change with the state itself
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			fault_n_r <= 1'b1;
			hold_r    <= 1'b0;
			tri_r     <= 1'b0;
			recirc_r  <= 1'b0;
			hs_r      <= 3'h0;
			ls_r      <= 3'h0;
			irq_r     <= 1'b0;
			rdata_r   <= '0;
		end else begin
			fault_n_r <= state_nxt != mlf_pkg::MLF_LATCHED;
			hold_r    <= hold_nxt_w;
			tri_r     <= hold_nxt_w && (action_nxt == mlf_pkg::MLF_TRISTATE);
			recirc_r  <= hold_nxt_w && (action_nxt == mlf_pkg::MLF_RECIRC);
			hs_r      <= {3{hold_nxt_w && (action_nxt == mlf_pkg::MLF_HS_BRAKE)}};
			ls_r      <= {3{hold_nxt_w && (action_nxt == mlf_pkg::MLF_LS_BRAKE)}};
			irq_r     <= |(status_nxt & mask_r);
			rdata_r   <= rd_en ? rd_mux_w : '0;
		end
	end

	assign rdata           = rdata_r;
	assign fault_out_n     = fault_n_r;
	assign bridge_hold     = hold_r;
	assign bridge_tristate = tri_r;
	assign bridge_recirc   = recirc_r;
	assign hs_on           = hs_r;
	assign ls_on           = ls_r;
	assign irq             = irq_r;

	// Checks on the response behaviour
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!resetn);

	sequence lock_in_idle;
		state_r == mlf_pkg::MLF_IDLE && lock_ev_w;
	endsequence

	sequence auto_start;
		lock_in_idle ##0 (mode_w >= mlf_pkg::MODE_AUTO_MIN && mode_w < mlf_pkg::MODE_REPORT && !limit_hit_w);
	endsequence

	sequence latched_clear;
		state_r == mlf_pkg::MLF_LATCHED && clear_w;
	endsequence

	sequence wait_done;
		state_r == mlf_pkg::MLF_WAIT && tim.done;
	endsequence

	chk_latch_fault_pin: assert property (lock_in_idle ##0 is_latch_w |=>
		state_r == mlf_pkg::MLF_LATCHED && !fault_out_n && bridge_hold)
		else $error("latched lock did not assert fault");

	chk_auto_recover: assert property (auto_start |=>
		state_r == mlf_pkg::MLF_WAIT && fault_out_n && bridge_hold)
		else $error("auto mode did not enter recovery wait");

	chk_report_only: assert property (lock_in_idle ##0 mode_w == mlf_pkg::MODE_REPORT |=>
		state_r == mlf_pkg::MLF_IDLE && !bridge_hold && status_r[mlf_pkg::ST_LOCK])
		else $error("report only mode acted on bridge");

	chk_detect_off: assert property (mode_w >= mlf_pkg::MODE_OFF_MIN |-> !lock_ev_w)
		else $error("lock seen while detection disabled");

	chk_brake_switches: assert property (bridge_hold && action_r == mlf_pkg::MLF_HS_BRAKE |->
		hs_on == 3'h7 && ls_on == 3'h0 && !bridge_tristate)
		else $error("high side brake pattern wrong");

	chk_speed_enable: assert property (abn_lock_w |-> cfg2_r[mlf_pkg::ABN_EN_BIT] &&
		elec_speed_hz > mlf_pkg::SPEED_W'((int'(cfg2_r[27:24]) + 1) * 250))
		else $error("overspeed lock without enable or trip");

	chk_sync_enable: assert property (!cfg2_r[mlf_pkg::SYNC_EN_BIT] |-> !sync_lock_w)
		else $error("sync loss lock while disabled");

	chk_nomotor_enable: assert property (!cfg2_r[mlf_pkg::NOMTR_EN_BIT] |-> !nomtr_lock_w)
		else $error("no motor lock while disabled");

	chk_retry_limit: assert property (lock_in_idle ##0 !is_latch_w && mode_w < mlf_pkg::MODE_REPORT
		&& limit_w != '0 && attempts_r == limit_w |=> state_r == mlf_pkg::MLF_LATCHED && status_r[mlf_pkg::ST_LIMIT])
		else $error("retry limit not enforced");

	chk_latch_hold: assert property (state_r == mlf_pkg::MLF_LATCHED && !clear_w |=>
		state_r == mlf_pkg::MLF_LATCHED && !fault_out_n)
		else $error("latched fault released without clear");

	chk_irq_level: assert property (##1 irq == |($past(status_nxt) & $past(mask_r)))
		else $error("interrupt output does not follow status");

	// Bridge pattern for the other held actions, and a quiet bridge when nothing is held
	chk_ls_brake: assert property (bridge_hold && action_r == mlf_pkg::MLF_LS_BRAKE |->
		ls_on == 3'h7 && hs_on == 3'h0 && !bridge_tristate && !bridge_recirc)
		else $error("low side brake pattern wrong");

	chk_tristate_hold: assert property (bridge_hold && action_r == mlf_pkg::MLF_TRISTATE |->
		bridge_tristate && !bridge_recirc && hs_on == 3'h0 && ls_on == 3'h0)
		else $error("tristate hold pattern wrong");

	chk_recirc_hold: assert property (bridge_hold && action_r == mlf_pkg::MLF_RECIRC |->
		bridge_recirc && !bridge_tristate && hs_on == 3'h0 && ls_on == 3'h0)
		else $error("recirculation hold pattern wrong");

	chk_idle_bridge: assert property (!bridge_hold |->
		!bridge_tristate && !bridge_recirc && hs_on == 3'h0 && ls_on == 3'h0)
		else $error("bridge driven while no response holds it");

	// Recovery never raises the fault pin; recovery and clear both hand the bridge back
	chk_wait_no_fault: assert property (state_r == mlf_pkg::MLF_WAIT |-> fault_out_n && bridge_hold)
		else $error("recovery wait drove fault or dropped bridge");

	chk_recover_release: assert property (wait_done |=>
		state_r == mlf_pkg::MLF_IDLE && !bridge_hold && status_r[mlf_pkg::ST_RECOV])
		else $error("bridge not released after recovery wait");

	chk_latch_clear: assert property (latched_clear |=>
		state_r == mlf_pkg::MLF_IDLE && fault_out_n && !bridge_hold && attempts_r == '0)
		else $error("clear did not release latched fault");

	chk_attempt_count: assert property (auto_start |=>
		attempts_r == $past(attempts_r) + mlf_pkg::CNT_W'(1))
		else $error("recovery attempt not counted");

	// A lock event is recorded even when a status clear lands in the same cycle
	chk_status_set_wins: assert property (lock_ev_w |=> status_r[mlf_pkg::ST_LOCK])
		else $error("lock event lost from status");

	// Trip point stays within its lowest and highest step
	chk_speed_floor: assert property (elec_speed_hz <= mlf_pkg::SPEED_W'(mlf_pkg::THR_STEP_HZ) |->
		!abn_lock_w)
		else $error("overspeed lock below lowest trip point");

	chk_speed_ceiling: assert property (cfg2_r[mlf_pkg::ABN_EN_BIT] &&
		elec_speed_hz > mlf_pkg::SPEED_W'((1 << mlf_pkg::THR_W) * mlf_pkg::THR_STEP_HZ) |-> abn_lock_w)
		else $error("overspeed above highest trip point missed");

	// Register path for the second settings word
	chk_cfg2_write: assert property (wr_en && addr == mlf_pkg::OFF_CFG2 |=> cfg2_r == $past(wdata))
		else $error("settings write did not land");

	chk_cfg2_read: assert property (rd_en && addr == mlf_pkg::OFF_CFG2 |=> rdata == $past(cfg2_r))
		else $error("settings read data wrong");
endmodule

// *** rtl/mlf_pkg.sv ***
// Constants, types and lookup functions for the motor lock fault block
package mlf_pkg;
	localparam int unsigned CLK_HZ      = 10_000_000;
	localparam int unsigned MS_PER_S    = 1000;
	localparam int unsigned TICK_MS     = 1;                           // Length of one wait tick in ms
	localparam int unsigned TICK_CYCLES = CLK_HZ / MS_PER_S * TICK_MS; // Cycles in one wait tick
	localparam int          TICK_W      = 24;
	localparam int          MS_W        = 14;
	localparam int          ADDR_W      = 8;
	localparam int          DATA_W      = 32;
	localparam int          SPEED_W     = 16;
	localparam int          CNT_W       = 5;

	// Register offsets
	localparam logic [ADDR_W-1:0] OFF_CFG1  = 8'h90;
	localparam logic [ADDR_W-1:0] OFF_CFG2  = 8'h94;
	localparam logic [ADDR_W-1:0] OFF_STAT  = 8'h98;
	localparam logic [ADDR_W-1:0] OFF_MASK  = 8'h9c;
	localparam logic [ADDR_W-1:0] OFF_CTRL  = 8'ha0;
	localparam logic [ADDR_W-1:0] OFF_STATE = 8'ha4;

	localparam logic [DATA_W-1:0] CFG1_RST = 32'h00000000;
	localparam logic [DATA_W-1:0] CFG2_RST = 32'h00000000;

	// Field layout
	localparam int MODE_LSB     = 3;
	localparam int MODE_W       = 4;
	localparam int WAIT_LSB     = 0;
	localparam int WAIT_W       = 3;
	localparam int ABN_EN_BIT   = 30;
	localparam int SYNC_EN_BIT  = 29;
	localparam int NOMTR_EN_BIT = 28;
	localparam int THR_LSB      = 24;
	localparam int THR_W        = 4;
	localparam int LIMIT_LSB    = 7;
	localparam int LIMIT_W      = 3;
	localparam int CTRL_CLEAR   = 0;

	// Response mode codes
	localparam logic [MODE_W-1:0] MODE_AUTO_MIN = 4'h4;
	localparam logic [MODE_W-1:0] MODE_REPORT   = 4'h8;
	localparam logic [MODE_W-1:0] MODE_OFF_MIN  = 4'h9;

	// Sticky status bits
	localparam int ST_LOCK  = 0;
	localparam int ST_LATCH = 1;
	localparam int ST_RECOV = 2;
	localparam int ST_LIMIT = 3;
	localparam int ST_W     = 4;

	localparam int unsigned THR_STEP_HZ = 250;

	typedef enum logic [1:0] {MLF_TRISTATE, MLF_RECIRC, MLF_HS_BRAKE, MLF_LS_BRAKE} mlf_action_t;
	typedef enum logic [1:0] {MLF_IDLE, MLF_WAIT, MLF_LATCHED} mlf_state_t;

	// Recovery wait in ms per code
	function automatic logic [MS_W-1:0] wait_ms(input logic [WAIT_W-1:0] code);
		case (code)
			3'h0:    wait_ms = 14'h0064;
			3'h1:    wait_ms = 14'h01f4;
			3'h2:    wait_ms = 14'h03e8;
			3'h3:    wait_ms = 14'h07d0;
			3'h4:    wait_ms = 14'h0bb8;
			3'h5:    wait_ms = 14'h1388;
			3'h6:    wait_ms = 14'h1d4c;
			default: wait_ms = 14'h2710;
		endcase
	endfunction

	// Recovery attempt limit, zero meaning no limit
	function automatic logic [CNT_W-1:0] retry_limit(input logic [LIMIT_W-1:0] code);
		case (code)
			3'h0:    retry_limit = 5'h00;
			3'h1:    retry_limit = 5'h02;
			3'h2:    retry_limit = 5'h03;
			3'h3:    retry_limit = 5'h05;
			3'h4:    retry_limit = 5'h07;
			3'h5:    retry_limit = 5'h0a;
			3'h6:    retry_limit = 5'h0f;
			default: retry_limit = 5'h14;
		endcase
	endfunction

	// Overspeed trip point in Hz, linear in steps
	function automatic logic [SPEED_W-1:0] trip_hz(input logic [THR_W-1:0] code);
		trip_hz = SPEED_W'((int'(code) + 1) * THR_STEP_HZ);
	endfunction
endpackage

// *** rtl/mlf_if.sv ***
// Handshake between the lock controller and its recovery wait timer
interface mlf_if;
	logic                    start;
	logic [mlf_pkg::MS_W-1:0] wait_ms;
	logic                    done;
	modport ctl (output start, output wait_ms, input done);
	modport tmr (input start, input wait_ms, output done);
endinterface

// *** rtl/mlf_timer.sv ***
// Recovery wait timer counting whole milliseconds from a tick divider
module mlf_timer #(
	parameter int unsigned TICK_CYCLES = mlf_pkg::TICK_CYCLES
) (
	input  wire logic mclk,
	input  wire logic resetn,
	mlf_if.tmr        tif
);
	logic [mlf_pkg::TICK_W-1:0] tick_cnt_r;
	logic [mlf_pkg::MS_W-1:0]   ms_cnt_r;
	logic [mlf_pkg::MS_W-1:0]   target_r;
	logic                       run_r;
	logic                       done_r;
	wire                        tick_w;
	wire                        last_w;

	// Tick enable once per ms, last tick ends the wait
	assign tick_w = run_r && (tick_cnt_r == mlf_pkg::TICK_W'(TICK_CYCLES - 1));
	assign last_w = tick_w && (ms_cnt_r == target_r - mlf_pkg::MS_W'(1));
	assign tif.done = done_r;

	// A new start restarts the count, so a stale wait never ends early
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			tick_cnt_r <= '0;
			ms_cnt_r   <= '0;
			target_r   <= '0;
			run_r      <= 1'b0;
			done_r     <= 1'b0;
		end else begin
			done_r <= last_w;
			if (tif.start) begin
				tick_cnt_r <= '0;
				ms_cnt_r   <= '0;
				target_r   <= tif.wait_ms;
				run_r      <= 1'b1;
			end else if (run_r) begin
				tick_cnt_r <= tick_w ? '0 : tick_cnt_r + mlf_pkg::TICK_W'(1);
				ms_cnt_r   <= tick_w ? ms_cnt_r + mlf_pkg::MS_W'(1) : ms_cnt_r;
				run_r      <= !last_w;
			end
		end
	end

	chk_wait_length: assert property (@(posedge mclk) disable iff (!resetn)
		done_r |-> $past(ms_cnt_r) == $past(target_r) - mlf_pkg::MS_W'(1) && !run_r)
		else $error("wait ended before its ms count");
endmodule

// *** bench/test_mlf_top.sv ***
// Self-checking bench for the motor lock fault block
module test_mlf_top;
	timeunit 1ns;
	timeprecision 1ps;

	// Short wait tick keeps the longest tested recovery wait to a few thousand cycles
	localparam int unsigned TICK = 4;

	logic                          mclk;
	logic                          resetn;
	logic [mlf_pkg::ADDR_W-1:0]    addr;
	logic [mlf_pkg::DATA_W-1:0]    wdata;
	logic                          wr_en;
	logic                          rd_en;
	logic [mlf_pkg::DATA_W-1:0]    rdata;
	logic [mlf_pkg::SPEED_W-1:0]   elec_speed_hz;
	logic                          sync_loss_lock;
	logic                          no_motor_lock;
	logic                          fault_out_n;
	logic                          bridge_hold;
	logic                          bridge_tristate;
	logic                          bridge_recirc;
	logic [2:0]                    hs_on;
	logic [2:0]                    ls_on;
	logic                          irq;
	logic [31:0]                   v;
	logic [31:0]                   w;
	logic [3:0]                    t;
	int                            err_count;
	int                            num_checks;
	int                            seed;
	int                            n;
	wire  logic [8:0]              br = {bridge_hold, bridge_tristate, bridge_recirc, hs_on, ls_on};

`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin $display("unexpected %s: expected %h seen %h", nm, exp, got); err_count++; end end

	mlf_top #(.TICK_CYCLES(TICK)) mlf_top_inst (
		.mclk            (mclk),
		.resetn          (resetn),
		.addr            (addr),
		.wdata           (wdata),
		.wr_en           (wr_en),
		.rd_en           (rd_en),
		.rdata           (rdata),
		.elec_speed_hz   (elec_speed_hz),
		.sync_loss_lock  (sync_loss_lock),
		.no_motor_lock   (no_motor_lock),
		.fault_out_n     (fault_out_n),
		.bridge_hold     (bridge_hold),
		.bridge_tristate (bridge_tristate),
		.bridge_recirc   (bridge_recirc),
		.hs_on           (hs_on),
		.ls_on           (ls_on),
		.irq             (irq)
	);

	// 10 MHz clock
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	// Bridge outputs expected while a response holds action a
	function automatic logic [8:0] exp_bridge(input logic [1:0] a);
		exp_bridge = {1'b1, a == 2'h0, a == 2'h1, (a == 2'h2) ? 3'h7 : 3'h0, (a == 2'h3) ? 3'h7 : 3'h0};
	endfunction

	// Recovery wait in clock cycles per wait code
	function automatic int exp_wait(input int c);
		int ms[8] = '{100, 500, 1000, 2000, 3000, 5000, 7500, 10000};
		exp_wait = ms[c] * TICK;
	endfunction

	// Overspeed trip point in Hz
	function automatic logic [15:0] exp_trip(input logic [3:0] c);
		exp_trip = 16'h00fa * ({12'h000, c} + 16'h0001);
	endfunction

	// One-cycle write strobe
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		wr_en <= 1'b1;
		addr  <= a;
		wdata <= d;
		@(posedge mclk);
		wr_en <= 1'b0;
	endtask

	// One-cycle read strobe, data taken in the following cycle only
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge mclk);
		rd_en <= 1'b1;
		addr  <= a;
		@(posedge mclk);
		rd_en <= 1'b0;
		#1;
		d = rdata;
	endtask

	// One-cycle lock event of kind k: 0 speed, 1 sync loss, 2 no motor
	task automatic ev(input int k, input logic [15:0] spd);
		@(posedge mclk);
		if (k == 0) elec_speed_hz <= spd;
		else if (k == 1) sync_loss_lock <= 1'b1;
		else no_motor_lock <= 1'b1;
		@(posedge mclk);
		elec_speed_hz  <= 16'h0000;
		sync_loss_lock <= 1'b0;
		no_motor_lock  <= 1'b0;
		@(posedge mclk);
		#1;
	endtask

	// Release latched fault and attempts, then wipe sticky status
	task automatic clr();
		wr(8'ha0, 32'h00000001);
		wr(8'h98, 32'h0000000f);
	endtask

	// Cycles until the recovery hold drops, bounded
	task automatic wait_release(output int cnt);
		cnt = 1;
		while (bridge_hold === 1'b1 && cnt < 50000) begin
			@(posedge mclk);
			#1;
			cnt++;
		end
	endtask

	task automatic end_sim();
		if (err_count == 0 && num_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	// Watchdog sized well above the whole sequence
	initial begin
		repeat (40000) @(posedge mclk);
		err_count++;
		end_sim();
	end

	// Main sequence
	initial begin
		err_count = 0;
		num_checks = 0;
		seed = 32'hdde62cb7;
		resetn = 1'b0;
		addr = 8'h00;
		wdata = 32'h00000000;
		wr_en = 1'b0;
		rd_en = 1'b0;
		elec_speed_hz = 16'h0000;
		sync_loss_lock = 1'b0;
		no_motor_lock = 1'b0;
		repeat (16) @(posedge mclk);
		resetn <= 1'b1;
		#1;
		`CHK("fault_out_n reset", 1'b1, fault_out_n)
		`CHK("bridge reset", 9'h000, br)
		rd(8'h94, v);
		`CHK("settings_two reset", 32'h00000000, v)
		w = $random(seed);
		wr(8'h94, w);
		rd(8'h94, v);
		`CHK("settings_two readback", w, v)
		rd(8'h10, v);
		`CHK("unmapped read", 32'h00000000, v)
		// Latched responses, held until cleared, with interrupt on the latched bit
		wr(8'h9c, 32'h00000002);
		for (int m = 0; m < 4; m++) begin
			wr(8'h94, 32'h10000000);
			wr(8'h90, 32'(m) << 3);
			ev(2, 16'h0000);
			`CHK("latched bridge", exp_bridge(2'(m)), br)
			`CHK("latched fault", 1'b0, fault_out_n)
			repeat (20) @(posedge mclk);
			#1;
			`CHK("latched hold", exp_bridge(2'(m)), br)
			rd(8'h98, v);
			`CHK("latched status", 32'h00000003, v)
			`CHK("irq set", 1'b1, irq)
			clr();
			rd(8'h98, v);
			`CHK("status cleared", 32'h00000000, v)
			`CHK("released", {1'b1, 9'h000, 1'b0}, {fault_out_n, br, irq})
		end
		// Each detector ignored when disabled, acted on when enabled
		for (int k = 0; k < 3; k++) begin
			wr(8'h94, 32'h00000000);
			wr(8'h90, 32'h00000000);
			ev(k, 16'hffff);
			`CHK("disabled detector", 9'h000, br)
			wr(8'h94, 32'h40000000 >> k);
			ev(k, 16'hffff);
			`CHK("enabled detector", 1'b0, fault_out_n)
			clr();
		end
		// Trip point: at threshold no trip, one above trips
		for (int i = 0; i < 3; i++) begin
			t = (i == 0) ? 4'h0 : (i == 1) ? 4'hf : 4'($random(seed));
			wr(8'h94, 32'h40000000 | (32'(t) << 24));
			ev(0, exp_trip(t));
			`CHK("at trip point", 9'h000, br)
			ev(0, exp_trip(t) + 16'h0001);
			`CHK("above trip point", 1'b0, fault_out_n)
			clr();
		end
		// Report only: status set, bridge untouched
		wr(8'h94, 32'h10000000);
		wr(8'h90, 32'h00000040);
		ev(2, 16'h0000);
		`CHK("report bridge", {1'b1, 9'h000}, {fault_out_n, br})
		rd(8'h98, v);
		`CHK("report status", 32'h00000001, v)
		clr();
		// Detection disabled for every code from 9 up
		for (int m = 9; m < 16; m++) begin
			wr(8'h90, 32'(m) << 3);
			ev(2, 16'h0000);
			rd(8'h98, v);
			`CHK("disabled mode status", 32'h00000000, v)
			`CHK("disabled mode bridge", 9'h000, br)
		end
		// Automatic recovery, wait codes 0 to 3 measured
		wr(8'h94, 32'h20000000);
		for (int m = 4; m < 8; m++) begin
			wr(8'h90, (32'(m) << 3) | 32'(m - 4));
			ev(1, 16'h0000);
			`CHK("auto bridge", {1'b1, exp_bridge(2'(m))}, {fault_out_n, br})
			wait_release(n);
			`CHK("wait length", 1'b1, n >= exp_wait(m - 4) - 2 && n <= exp_wait(m - 4) + 6)
			rd(8'h98, v);
			`CHK("auto status", 32'h00000005, v)
			clr();
		end
		// Attempt limit of two: the third lock latches
		wr(8'h94, 32'h20000080);
		wr(8'h90, 32'h00000020);
		repeat (2) begin
			ev(1, 16'h0000);
			`CHK("retry hold", {1'b1, 1'b1}, {fault_out_n, bridge_hold})
			wait_release(n);
		end
		ev(1, 16'h0000);
		`CHK("limit latched", 1'b0, fault_out_n)
		rd(8'h98, v);
		`CHK("limit status", 32'h0000000f, v)
		clr();
		`CHK("limit cleared", {1'b1, 9'h000}, {fault_out_n, br})
		end_sim();
	end
endmodule
